// ==== hw/flash_erase_host.sv ====
// module: apb controlled host that sequences erase commands to the flash
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
module flash_erase_host #(
    parameter int window_len = flash_erase_pkg::window_cycles,
    parameter logic [7:0] unlock1_data = flash_erase_pkg::default_unlock1_data,
    parameter logic [7:0] unlock2_data = flash_erase_pkg::default_unlock2_data,
    parameter logic [19:0] unlock1_addr = flash_erase_pkg::default_unlock1_addr,
    parameter logic [19:0] unlock2_addr = flash_erase_pkg::default_unlock2_addr,
    parameter logic [7:0] setup_code = flash_erase_pkg::default_setup_code,
    parameter logic [7:0] sector_code = flash_erase_pkg::default_sector_code,
    parameter logic [7:0] chip_code = flash_erase_pkg::default_chip_code,
    parameter logic [7:0] resume_code = flash_erase_pkg::default_resume_code,
    parameter logic [7:0] reset_code = flash_erase_pkg::default_reset_code,
    parameter logic [7:0] autoselect_code = flash_erase_pkg::default_autoselect_code
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] flash_addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic flash_reset_n,
    input wire logic ready_busy_in,
    output logic window_open
);
    import flash_erase_pkg::*;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_wait = 2'b10,
        st_reset = 2'b11
    } state_t;

    state_t state;
    logic [2:0] ctrl_cmd;
    logic [19:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] read_value;
    logic [2:0] step;
    logic [2:0] last_step;
    logic busy;
    logic done_flag;
    logic suspended;
    logic is_read;
    logic [31:0] window_count;
    logic [15:0] pulse_count;
    logic cyc_start;
    logic cyc_write;
    logic [19:0] cyc_addr;
    logic [7:0] cyc_data;
    logic [7:0] cyc_rdata;
    logic cyc_done;
    logic wr_access;
    logic go;
    logic ready_sync;

    assign wr_access = psel && penable && pwrite;
    assign go = wr_access && paddr == ctrl_offset && pwdata[ctrl_go_bit] && !busy;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign ready_sync = ready_busy_in;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_cmd <= reg_reset[2:0];
            addr_reg <= reg_reset[19:0];
            data_reg <= reg_reset[7:0];
        end
        else if (wr_access && !busy)
        begin
            if (paddr == ctrl_offset)
                ctrl_cmd <= pwdata[ctrl_cmd_lsb +: ctrl_cmd_width];
            if (paddr == addr_offset)
                addr_reg <= pwdata[19:0];
            if (paddr == data_offset)
                data_reg <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            ctrl_offset: prdata = {29'h0, ctrl_cmd};
            addr_offset: prdata = {12'h000, addr_reg};
            data_offset: prdata = {24'h000000, data_reg};
            status_offset: prdata = {28'h0, suspended, ready_sync, done_flag, busy};
            // read back carries data_polling_bit, toggle_bit_one, erase_timer_flag, sector_toggle_bit
            rdata_offset: prdata = {24'h000000, read_value};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // command step table
    // ----------------------------------------
    always_comb
    begin
        cyc_write = 1'b1;
        cyc_addr = unlock1_addr;
        cyc_data = unlock1_data;
        unique case (step)
            3'd0: cyc_data = unlock1_data;
            3'd1:
            begin
                cyc_addr = unlock2_addr;
                cyc_data = unlock2_data;
            end
            3'd2: cyc_data = setup_code;
            3'd3: cyc_data = unlock1_data;
            3'd4:
            begin
                cyc_addr = unlock2_addr;
                cyc_data = unlock2_data;
            end
            default:
            begin
                cyc_addr = addr_reg;
                cyc_data = sector_code;
            end
        endcase
        unique case (op_t'(ctrl_cmd))
            op_chip_erase:
                if (step == 3'd5)
                    cyc_data = chip_code;
            op_add_sector:
            begin
                cyc_addr = addr_reg;
                cyc_data = sector_code;
            end
            op_suspend:
            begin
                cyc_addr = addr_reg;
                cyc_data = suspend_code;
            end
            op_resume:
            begin
                cyc_addr = addr_reg;
                cyc_data = resume_code;
            end
            op_read:
            begin
                cyc_write = 1'b0;
                cyc_addr = addr_reg;
            end
            op_reset_cmd:
            begin
                cyc_addr = addr_reg;
                cyc_data = reset_code;
            end
            op_autoselect:
                if (step == 3'd2)
                    cyc_data = autoselect_code;
            default:
                cyc_write = 1'b1;
        endcase
    end

    // ----------------------------------------
    // sequence control
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= st_idle;
            step <= 3'd0;
            last_step <= 3'd0;
            busy <= 1'b0;
            done_flag <= 1'b0;
            is_read <= 1'b0;
            cyc_start <= 1'b0;
            pulse_count <= 16'h0000;
            flash_reset_n <= 1'b1;
        end
        else
        begin
            cyc_start <= 1'b0;
            unique case (state)
                st_idle:
                    if (go)
                    begin
                        busy <= 1'b1;
                        done_flag <= 1'b0;
                        is_read <= pwdata[2:0] == op_read;
                        unique case (op_t'(pwdata[2:0]))
                            op_sector_erase, op_chip_erase:
                            begin
                                step <= 3'd0;
                                last_step <= 3'd5;
                            end
                            op_autoselect:
                            begin
                                step <= 3'd0;
                                last_step <= 3'd2;
                            end
                            default:
                            begin
                                step <= 3'd5;
                                last_step <= 3'd5;
                            end
                        endcase
                        if (pwdata[2:0] == op_reset_cmd && pwdata[ctrl_go_bit + 1])
                        begin
                            // hardware reset pulse aborts any erase
                            flash_reset_n <= 1'b0;
                            pulse_count <= 16'h0000;
                            state <= st_reset;
                        end
                        else
                        begin
                            cyc_start <= 1'b1;
                            state <= st_write;
                        end
                    end
                st_write:
                    state <= st_wait;
                st_wait:
                    if (cyc_done)
                    begin
                        if (step == last_step)
                        begin
                            busy <= 1'b0;
                            done_flag <= 1'b1;
                            state <= st_idle;
                        end
                        else
                        begin
                            step <= step + 3'd1;
                            cyc_start <= 1'b1;
                            state <= st_write;
                        end
                    end
                st_reset:
                begin
                    pulse_count <= pulse_count + 16'h0001;
                    if (pulse_count == 16'(pulse_cycles - 1))
                    begin
                        flash_reset_n <= 1'b1;
                        busy <= 1'b0;
                        done_flag <= 1'b1;
                        state <= st_idle;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // read capture and suspend tracking
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            read_value <= 8'h00;
            suspended <= 1'b0;
        end
        else if (state == st_wait && cyc_done)
        begin
            if (is_read)
                read_value <= cyc_rdata;
            if (ctrl_cmd == op_suspend)
                suspended <= 1'b1;
            else if (ctrl_cmd == op_resume || ctrl_cmd == op_reset_cmd)
                suspended <= 1'b0;
        end
        else if (state == st_reset)
            suspended <= 1'b0;
    end

    // ----------------------------------------
    // sector loading window: host must keep extra writes inside it
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            window_count <= 32'h0;
        else if (state == st_wait && cyc_done && step == 3'd5 &&
                 (ctrl_cmd == op_sector_erase || ctrl_cmd == op_add_sector))
            window_count <= 32'(window_len);
        else if (state == st_wait && cyc_done && ctrl_cmd != op_read)
            window_count <= 32'h0;
        else if (state == st_reset)
            window_count <= 32'h0;
        else if (window_count != 32'h0)
            window_count <= window_count - 32'h1;
    end

    // software masks its interrupts while this is high
    assign window_open = window_count != 32'h0;

    flash_bus_cycle #(
        .strobe_len(strobe_cycles)
    ) u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(cyc_start),
        .write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .dq_in(dq_in),
        .flash_addr(flash_addr),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .ce_n(ce_n),
        .we_n(we_n),
        .oe_n(oe_n),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );
endmodule : flash_erase_host

// ==== hw/flash_erase_pkg.sv ====
// package: constants for the flash erase controller (host side)
package flash_erase_pkg;
    // apb register offsets
    localparam logic [11:0] ctrl_offset = 12'h000;
    localparam logic [11:0] addr_offset = 12'h004;
    localparam logic [11:0] data_offset = 12'h008;
    localparam logic [11:0] status_offset = 12'h00c;
    localparam logic [11:0] rdata_offset = 12'h010;
    // ctrl field positions
    localparam int ctrl_cmd_lsb = 0;
    localparam int ctrl_cmd_width = 3;
    localparam int ctrl_go_bit = 4;
    // status field positions
    localparam int status_busy_bit = 0;
    localparam int status_done_bit = 1;
    localparam int status_ready_bit = 2;
    localparam int status_suspended_bit = 3;
    // data status bits inside a status read
    localparam int data_polling_pos = 7;
    localparam int toggle_one_pos = 6;
    localparam int erase_timer_pos = 3;
    localparam int sector_toggle_pos = 2;
    // reset values
    localparam logic [31:0] reg_reset = 32'h0000_0000;
    // command codes
    localparam logic [7:0] suspend_code = 8'hb0;
    localparam logic [7:0] default_unlock1_data = 8'haa;
    localparam logic [7:0] default_unlock2_data = 8'h55;
    localparam logic [7:0] default_setup_code = 8'h80;
    localparam logic [7:0] default_sector_code = 8'h30;
    localparam logic [7:0] default_chip_code = 8'h10;
    localparam logic [7:0] default_resume_code = 8'h30;
    localparam logic [7:0] default_reset_code = 8'hf0;
    localparam logic [7:0] default_autoselect_code = 8'h90;
    localparam logic [19:0] default_unlock1_addr = 20'h00555;
    localparam logic [19:0] default_unlock2_addr = 20'h002aa;
    // timing
    localparam int clk_period_ns = 10;
    localparam int window_ns = 50000;
    localparam int window_cycles = window_ns / clk_period_ns;
    localparam int strobe_ns = 50;
    localparam int strobe_cycles = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int pulse_ns = 500;
    localparam int pulse_cycles = (pulse_ns + clk_period_ns - 1) / clk_period_ns;
    // host commands
    typedef enum logic [2:0] {
        op_sector_erase = 3'b000,
        op_chip_erase = 3'b001,
        op_add_sector = 3'b010,
        op_suspend = 3'b011,
        op_resume = 3'b100,
        op_read = 3'b101,
        op_reset_cmd = 3'b110,
        op_autoselect = 3'b111
    } op_t;
endpackage : flash_erase_pkg

// ==== hw/flash_bus_cycle.sv ====
// module: one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ns
module flash_bus_cycle #(
    parameter int strobe_len = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic write,
    input wire logic [19:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in,
    output logic [19:0] flash_addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [7:0] rdata,
    output logic done
);
    logic [15:0] count;
    logic active;
    logic is_write;

    // ----------------------------------------
    // strobe timing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active <= 1'b0;
            count <= 16'h0000;
            is_write <= 1'b0;
            flash_addr <= 20'h00000;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            rdata <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!active && start)
            begin
                active <= 1'b1;
                count <= 16'h0000;
                is_write <= write;
                flash_addr <= addr;
                dq_out <= wdata;
                dq_oe <= write;
                ce_n <= 1'b0;
                we_n <= !write;
                oe_n <= write;
            end
            else if (active)
            begin
                count <= count + 16'h0001;
                if (count == 16'(strobe_len - 1))
                begin
                    // write data latches on this rising we_n edge
                    we_n <= 1'b1;
                    oe_n <= 1'b1;
                    if (!is_write)
                        rdata <= dq_in;
                end
                else if (count == 16'(strobe_len))
                begin
                    ce_n <= 1'b1;
                    dq_oe <= 1'b0;
                    active <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : flash_bus_cycle

// ==== dv/flash_erase_host_props.sv ====
// checker: port level assertions for the flash erase host
`timescale 1ns/1ns
module flash_erase_host_props #(
    parameter int window_len = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic dq_oe,
    input wire logic flash_reset_n,
    input wire logic window_open
);
    localparam int win_max = window_len + 4;
    int since_we;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last write strobe ended
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            since_we <= 0;
        else if (!we_n)
            since_we <= 0;
        else if (since_we < 100000)
            since_we <= since_we + 1;
    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    a_apb_zero_wait: assert property (psel && penable |-> pready && !pslverr)
        else $error("apb access stalled or flagged");
    a_strobe_exclusive: assert property (!(!we_n && !oe_n))
        else $error("write and read strobes low together");
    a_write_drives_bus: assert property (!we_n |-> dq_oe && !ce_n)
        else $error("write strobe without chip select or data");
    a_read_released_bus: assert property (!oe_n |-> !dq_oe)
        else $error("data driven during a read");
    a_write_pulse_len: assert property ($fell(we_n) |-> ##[3:8] $rose(we_n))
        else $error("write strobe length wrong");
    a_reset_pulse_len: assert property ($fell(flash_reset_n) |-> ##[40:60] $rose(flash_reset_n))
        else $error("flash reset pulse length wrong");
    a_reset_quiet: assert property (!flash_reset_n |-> we_n && ce_n)
        else $error("write during flash reset");
    a_window_opens_idle: assert property ($rose(window_open) |-> we_n && ce_n && $past(we_n))
        else $error("window opened inside a write");
    a_window_timed: assert property (window_open |-> since_we <= win_max)
        else $error("window outlived its time from the last write");
endmodule : flash_erase_host_props
bind flash_erase_host flash_erase_host_props #(.window_len(window_len)) flash_erase_host_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_oe(dq_oe), .flash_reset_n(flash_reset_n),
    .window_open(window_open));

// ==== dv/flash_dev_model.sv ====
// partner model: behavioural flash device answering erase commands
`timescale 1ns/1ns
module flash_dev_model #(
    parameter int win_len = 50,
    parameter int erase_len = 400
) (
    input wire logic pclk,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] dq_out,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic flash_reset_n,
    output logic [7:0] dq_in,
    output logic ready_busy_in
);
    import flash_erase_pkg::*;
    typedef enum logic [2:0] {s_read, s_window, s_erase, s_chip, s_susp} mode_t;
    mode_t mode = s_read;
    logic [255:0] sel = '0;
    logic [7:0] last = 8'h00;
    logic prev_we = 1'b1, prev_oe = 1'b1, setup = 1'b0, tog = 1'b0, ident = 1'b0;
    int tmr = 0, writes = 0, sectors = 0;
    // --------------------------------------------------------------
    // command decode at the end of each write strobe
    // --------------------------------------------------------------
    always @(posedge pclk)
    begin
        prev_we <= we_n;
        prev_oe <= oe_n;
        if (!oe_n)
            last <= dq_in;
        if (prev_oe && !oe_n && !ready_busy_in)
            tog <= ~tog;
        if (!flash_reset_n)
        begin
            mode <= s_read;
            setup <= 1'b0;
            ident <= 1'b0;
            sel <= '0;
        end
        else if (!prev_we && we_n)
        begin
            writes <= writes + 1;
            if (mode == s_read && dq_out == default_setup_code)
                setup <= 1'b1;
            else if (mode == s_read && setup && dq_out == default_chip_code)
            begin
                mode <= s_chip;
                setup <= 1'b0;
                tmr <= 0;
            end
            else if (mode inside {s_read, s_window} && (setup || mode == s_window) && dq_out == default_sector_code)
            begin
                mode <= s_window;
                setup <= 1'b0;
                sel[flash_addr[19:12]] <= 1'b1;
                sectors <= sectors + 1;
                tmr <= 0;
            end
            else if (mode inside {s_window, s_erase} && dq_out == suspend_code)
                mode <= s_susp;
            else if (mode == s_susp && dq_out == default_resume_code)
                mode <= s_erase;
            else if (mode inside {s_read, s_susp} && dq_out == default_autoselect_code)
                ident <= 1'b1;
            else if (mode == s_chip)
                mode <= s_chip;
            else if (mode == s_window)
            begin
                mode <= s_read;
                sel <= '0;
            end
        end
        else if (mode inside {s_window, s_erase, s_chip})
        begin
            tmr <= tmr + 1;
            if (mode == s_window && tmr >= win_len)
            begin
                mode <= s_erase;
                tmr <= 0;
            end
            else if (mode != s_window && tmr >= erase_len)
            begin
                mode <= s_read;
                sel <= '0;
            end
        end
    end
    // released data lines show the inverse of the last value
    always_comb
    begin
        ready_busy_in = !(mode inside {s_window, s_erase, s_chip});
        if (oe_n || ce_n)
            dq_in = ~last;
        else if (sel[flash_addr[19:12]] || mode == s_chip)
            dq_in = {mode == s_susp, tog, 2'b00, mode inside {s_erase, s_chip}, tog, 2'b00};
        else
            dq_in = flash_addr[7:0] ^ 8'h5a;
    end
endmodule : flash_dev_model

// ==== dv/flash_erase_host_tb.sv ====
// testbench: erase host driven over apb against a flash device model
`timescale 1ns/1ns
module flash_erase_host_tb;
    import flash_erase_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dq_oe, ce_n, we_n, oe_n;
    logic flash_reset_n, ready_busy_in, window_open;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [19:0] flash_addr;
    logic [7:0] dq_out, dq_in;
    int miscompares = 0;
    int checked = 0;
    int n;
    flash_erase_host #(.window_len(50)) flash_erase_host_inst (.*);
    flash_dev_model #(.win_len(50), .erase_len(400)) flash_dev_model_inst (.*);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // --------------------------------------------------------------
    // access tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run(input op_t o, input logic [19:0] a, input logic x);
        int i;
        apb(1'b1, addr_offset, {12'h000, a});
        apb(1'b1, ctrl_offset, {26'h0, x, 1'b1, 1'b0, o});
        i = 0;
        do
        begin
            apb(1'b0, status_offset, 32'h0);
            i++;
        end
        while (q[status_done_bit] !== 1'b1 && i < 100);
        chk(32'(q[status_done_bit]), 32'h1, "command completes");
    endtask : run
    task automatic sts(input logic [31:0] m, input logic [31:0] e, input string what);
        apb(1'b0, status_offset, 32'h0);
        chk(q & m, e, what);
    endtask : sts
    task automatic fread(input logic [19:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        run(op_read, a, 1'b0);
        apb(1'b0, rdata_offset, 32'h0);
        chk(q & m, e, what);
    endtask : fread
    task automatic wait_ready;
        int i;
        i = 0;
        do
        begin
            apb(1'b0, status_offset, 32'h0);
            i++;
        end
        while (q[status_ready_bit] !== 1'b1 && i < 400);
        chk(32'(q[status_ready_bit]), 32'h1, "device ready again");
    endtask : wait_ready
    task automatic results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    initial
    begin
        #100000;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        sts(32'hf, 32'h4, "status after reset");
        apb(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0, "unmapped read");
        $display("test registers done");
        n = flash_dev_model_inst.writes;
        run(op_sector_erase, 20'h34000, 1'b0);
        chk(32'(flash_dev_model_inst.writes - n), 32'h6, "sector erase writes");
        chk(32'(window_open), 32'h1, "window open");
        run(op_add_sector, 20'h12000, 1'b0);
        chk(32'(flash_dev_model_inst.sectors), 32'h2, "sectors loaded");
        fread(20'h12010, 32'h88, 32'h00, "status in window");
        repeat (60) @(posedge pclk);
        sts(32'h4, 32'h0, "busy while erasing");
        fread(20'h12010, 32'h88, 32'h08, "status while erasing");
        fread(20'h50022, 32'hff, 32'h78, "array beside erase");
        $display("test sector erase done");
        run(op_suspend, 20'h12000, 1'b0);
        sts(32'hc, 32'hc, "suspended and ready");
        fread(20'h12010, 32'h80, 32'h80, "suspended sector status");
        fread(20'h50022, 32'hff, 32'h78, "array while suspended");
        run(op_autoselect, 20'h00000, 1'b0);
        chk(32'(flash_dev_model_inst.ident), 32'h1, "autoselect while suspended");
        run(op_resume, 20'h12000, 1'b0);
        run(op_resume, 20'h12000, 1'b0);
        sts(32'h4, 32'h0, "erase resumed");
        $display("test suspend done");
        run(op_reset_cmd, 20'h00000, 1'b1);
        sts(32'h4, 32'h4, "ready after hardware reset");
        $display("test hardware reset done");
        run(op_chip_erase, 20'h00000, 1'b0);
        run(op_suspend, 20'h00000, 1'b0);
        sts(32'h4, 32'h0, "suspend ignored in chip erase");
        run(op_autoselect, 20'h00000, 1'b0);
        chk(32'(flash_dev_model_inst.ident), 32'h0, "autoselect refused in erase");
        wait_ready();
        fread(20'h00033, 32'hff, 32'h69, "array after chip erase");
        $display("test chip erase done");
        run(op_sector_erase, 20'h34000, 1'b0);
        run(op_reset_cmd, 20'h00000, 1'b0);
        sts(32'h4, 32'h4, "window abandoned");
        $display("test window abort done");
        results();
    end
endmodule : flash_erase_host_tb
